/* File: perf_event_counter_control.sv */
// module: one programmable performance event counter with its control register
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// Functional notes
// - field 7:0 selects which event source line feeds the counter
// - field 15:8 masks the qualifier lines of the selected event
// - user bit 16 counts while privilege level is one, two or three
// - kernel bit 17 counts while privilege level is zero
// - edge bit 18 counts only rising transitions of the qualified condition
// - interrupt bit 20 raises an interrupt request on counter overflow
// - counter counts upward only; overflow is the wrap from maximum to zero
// - any-thread bit 21 chooses own-thread or any-thread event source
// - enable bit 22 clear holds the counter still
// - invert bit 23 picks greater-or-equal or less-than threshold compare
// - zero threshold in 31:24 leaves counting unaffected by comparison
// - nonzero threshold adds exactly one when the compare holds
module perf_event_counter_control
#(
   parameter int NUM_EVENTS = 256,
   parameter int QUAL_W     = 8,
   parameter int INC_W      = 8,
   parameter int CNT_W      = 48
)
(
   // clock, reset, enable
   input  wire logic                                   clk_sys,
   input  wire logic                                   rst,
   input  wire logic                                   clk_en,
   // register port
   input  wire logic [perf_counter_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [31:0]                            reg_wdata,
   input  wire logic                                   reg_wr,
   input  wire logic                                   reg_rd,
   output logic      [31:0]                            reg_rdata,
   // event sources, same clock domain
   input  wire logic [NUM_EVENTS-1:0]                  evt_own,
   input  wire logic [NUM_EVENTS-1:0]                  evt_any,
   input  wire logic [QUAL_W-1:0]                      qual_own,
   input  wire logic [QUAL_W-1:0]                      qual_any,
   input  wire logic [INC_W-1:0]                       inc_own,
   input  wire logic [INC_W-1:0]                       inc_any,
   input  wire logic [1:0]                             priv_level,
   // to local interrupt controller
   output logic                                        ovf_irq
);
   import perf_counter_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0]      counter_event_control_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic             overflow_r;
   logic             qual_prev_r;
   logic             ovf_irq_r;
   logic [31:0]      rdata_r;

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   logic [7:0]        event_selector;
   logic [7:0]        event_qualifier_mask;
   logic              user_level_count;
   logic              kernel_level_count;
   logic              edge_mode;
   logic              int_enable;
   logic              any_thread_count;
   logic              count_enable;
   logic              threshold_invert;
   logic [7:0]        threshold_value;

   assign event_selector       = counter_event_control_r[SEL_MSB:SEL_LSB];
   assign event_qualifier_mask = counter_event_control_r[QUAL_MSB:QUAL_LSB];
   assign user_level_count     = counter_event_control_r[BIT_USER];
   assign kernel_level_count   = counter_event_control_r[BIT_KERNEL];
   assign edge_mode            = counter_event_control_r[BIT_EDGE];
   assign int_enable           = counter_event_control_r[BIT_INT_EN];
   assign any_thread_count     = counter_event_control_r[BIT_ANY_THREAD];
   assign count_enable         = counter_event_control_r[BIT_ENABLE];
   assign threshold_invert     = counter_event_control_r[BIT_INVERT];
   assign threshold_value      = counter_event_control_r[THR_MSB:THR_LSB];

   // ----------------------------------------------------------------
   // event qualification
   // ----------------------------------------------------------------
   logic [NUM_EVENTS-1:0] evt_src;
   logic [QUAL_W-1:0]     qual_src;
   logic [INC_W-1:0]      inc_src;
   logic                  evt_hit;
   logic                  qual_ok;
   logic                  priv_ok;
   logic                  thr_ok;
   logic                  cond;
   logic                  cond_step;
   logic                  do_inc;

   assign evt_src  = any_thread_count ? evt_any  : evt_own;
   assign qual_src = any_thread_count ? qual_any : qual_own;
   assign inc_src  = any_thread_count ? inc_any  : inc_own;

   // event selection: out-of-range selector never hits
   assign evt_hit  = (32'(event_selector) < NUM_EVENTS) ? evt_src[event_selector] : 1'b0;
   // zero mask means no refinement, otherwise any masked qualifier line must be active
   assign qual_ok  = (event_qualifier_mask == 8'h00) ||
                     ((8'(qual_src) & event_qualifier_mask) != 8'h00);

   assign priv_ok  = (user_level_count   && (priv_level != PRIV_KERNEL)) ||
                     (kernel_level_count && (priv_level == PRIV_KERNEL));

   // threshold compare on the per-cycle event count
   always_comb
   begin
      if (threshold_value == 8'h00)
         thr_ok = 1'b1;
      else if (threshold_invert)
         thr_ok = (8'(inc_src) < threshold_value);
      else
         thr_ok = (8'(inc_src) >= threshold_value);
   end

   // without a threshold the condition is the event itself; with one the event must also pass the compare
   assign cond      = evt_hit && qual_ok && priv_ok &&
                      ((threshold_value == 8'h00) ? 1'b1 : thr_ok);
   assign cond_step = edge_mode ? (cond && !qual_prev_r) : cond;
   assign do_inc    = count_enable && cond_step;

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         counter_event_control_r <= CONTROL_RESET;
      else if (clk_en && reg_wr && (reg_addr == ADDR_CONTROL))
         counter_event_control_r <= reg_wdata & CONTROL_WMASK;
   end

   // ----------------------------------------------------------------
   // edge history
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         qual_prev_r <= 1'b0;
      else if (clk_en)
         qual_prev_r <= cond;
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_comb
   begin
      count_nxt = count_r;
      if (do_inc)
         count_nxt = count_r + CNT_W'(1);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         count_r <= '0;
      else if (clk_en)
      begin
         if (reg_wr && (reg_addr == ADDR_COUNT_LO))
            count_r[31:0] <= reg_wdata;
         else if (reg_wr && (reg_addr == ADDR_COUNT_HI))
            count_r[CNT_W-1:32] <= reg_wdata[CNT_W-33:0];
         else
            count_r <= count_nxt;
      end
   end

   // ----------------------------------------------------------------
   // overflow flag and interrupt request
   // ----------------------------------------------------------------
   logic wrap;
   assign wrap = do_inc && (count_r == {CNT_W{1'b1}});

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         overflow_r <= 1'b0;
      else if (clk_en)
      begin
         // set wins over a write-one clear in the same cycle
         if (wrap)
            overflow_r <= 1'b1;
         else if (reg_wr && (reg_addr == ADDR_STATUS) && reg_wdata[STAT_OVERFLOW])
            overflow_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ovf_irq_r <= 1'b0;
      else if (clk_en)
         ovf_irq_r <= wrap && int_enable;
   end

   assign ovf_irq = ovf_irq_r;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rdata_r <= ZERO_WORD;
      else if (clk_en)
      begin
         rdata_r <= ZERO_WORD;
         if (reg_rd)
         begin
            case (reg_addr)
               ADDR_CONTROL:    rdata_r <= counter_event_control_r;
               ADDR_COUNT_LO:   rdata_r <= count_r[31:0];
               ADDR_COUNT_HI:   rdata_r <= 32'(count_r[CNT_W-1:32]);
               ADDR_STATUS:     rdata_r <= 32'({cond, overflow_r});
               ADDR_PRIV_LEVEL: rdata_r <= 32'(priv_level);
               default:         rdata_r <= ZERO_WORD;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_r;
endmodule

/* File: perf_counter_pkg.sv */
// package: register layout, field positions and widths for the event counter control
package perf_counter_pkg;
   // register map (word addresses on the plain register port)
   localparam int          ADDR_W            = 4;
   localparam logic [3:0]  ADDR_CONTROL      = 4'h0;
   localparam logic [3:0]  ADDR_COUNT_LO     = 4'h1;
   localparam logic [3:0]  ADDR_COUNT_HI     = 4'h2;
   localparam logic [3:0]  ADDR_STATUS       = 4'h3;
   localparam logic [3:0]  ADDR_PRIV_LEVEL   = 4'h4;

   // control register fields
   localparam int          SEL_LSB           = 0;
   localparam int          SEL_MSB           = 7;
   localparam int          QUAL_LSB          = 8;
   localparam int          QUAL_MSB          = 15;
   localparam int          BIT_USER          = 16;
   localparam int          BIT_KERNEL        = 17;
   localparam int          BIT_EDGE          = 18;
   localparam int          BIT_INT_EN        = 20;
   localparam int          BIT_ANY_THREAD    = 21;
   localparam int          BIT_ENABLE        = 22;
   localparam int          BIT_INVERT        = 23;
   localparam int          THR_LSB           = 24;
   localparam int          THR_MSB           = 31;
   localparam logic [31:0] CONTROL_WMASK     = 32'hfff7ffff;
   localparam logic [31:0] CONTROL_RESET     = 32'h00000000;

   // status register fields
   localparam int          STAT_OVERFLOW     = 0;
   localparam int          STAT_QUALIFIED    = 1;

   // privilege level that counts as kernel
   localparam logic [1:0]  PRIV_KERNEL       = 2'h0;

   localparam logic [31:0] ZERO_WORD         = 32'h00000000;
endpackage

/* File: perf_counter_chk.sv */
// checker: port-level properties of the event counter control block
`timescale 1ns/1ps
module perf_counter_chk
   import perf_counter_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              clk_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   input wire logic [1:0]        priv_level,
   input wire logic              ovf_irq
);
   logic [31:0] ctl_r;
   logic        priv_ok;
   // shadow of the control register as software wrote it
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         ctl_r <= '0;
      else if (clk_en && reg_wr && reg_addr == ADDR_CONTROL)
         ctl_r <= reg_wdata & CONTROL_WMASK;
   assign priv_ok = ctl_r[BIT_USER] && priv_level != PRIV_KERNEL || ctl_r[BIT_KERNEL] && priv_level == PRIV_KERNEL;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_rd(logic [ADDR_W-1:0] a);
      clk_en && reg_rd && reg_addr == a;
   endsequence
   property p_ctl; s_rd(ADDR_CONTROL) |=> reg_rdata == $past(ctl_r); endproperty
   property p_rsvd; s_rd(ADDR_CONTROL) |=> reg_rdata[19] == 1'b0; endproperty
   property p_unmap; clk_en && reg_rd && reg_addr > ADDR_PRIV_LEVEL |=> reg_rdata == ZERO_WORD; endproperty
   property p_privrd; s_rd(ADDR_PRIV_LEVEL) |=> reg_rdata == {30'h0, $past(priv_level)}; endproperty
   property p_pulse; ovf_irq |=> !ovf_irq; endproperty
   property p_int; ovf_irq |-> $past(ctl_r[BIT_INT_EN]); endproperty
   property p_en; ovf_irq |-> $past(ctl_r[BIT_ENABLE]); endproperty
   property p_priv; ovf_irq |-> $past(priv_ok); endproperty
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_privrd: assert property (p_privrd) else $error("privilege readback wrong");
   a_pulse: assert property (p_pulse) else $error("overflow pulse too long");
   a_int: assert property (p_int) else $error("overflow irq while disabled");
   a_en: assert property (p_en) else $error("overflow while counter off");
   a_priv: assert property (p_priv) else $error("overflow at wrong privilege");
endmodule
bind perf_event_counter_control perf_counter_chk u_chk (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .priv_level(priv_level), .ovf_irq(ovf_irq));

/* File: evt_src_model.sv */
// partner model: core event lines for one event source
`timescale 1ns/1ps
module evt_src_model
#(
   parameter int N   = 256,
   parameter int SEL = 5
)
(
   // stimulus from the bench
   input  wire logic       hit,
   input  wire logic       any,
   input  wire logic [7:0] q,
   input  wire logic [7:0] inc,
   // lines into the counter
   output logic [N-1:0]    e_own,
   output logic [N-1:0]    e_any,
   output logic [7:0]      q_own,
   output logic [7:0]      q_any,
   output logic [7:0]      i_own,
   output logic [7:0]      i_any
);
   // any set: the sibling thread raised it, own thread sees no event and no increment
   always_comb
   begin
      e_own      = '0;
      e_any      = '0;
      e_own[SEL] = hit & ~any;
      e_any[SEL] = hit;
      i_own      = any ? 8'h00 : inc;
      i_any      = inc;
   end
   assign q_own = q;
   assign q_any = q;
endmodule

/* File: tb.sv */
// testbench: register port, qualifiers and overflow of the event counter
`timescale 1ns/1ps
module tb;
   import perf_counter_pkg::*;
   logic              clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, hit = 0, any = 0, ovf_irq, clk_en = 1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [31:0]       reg_wdata = '0, reg_rdata;
   logic [7:0]        q = '0, inc = '0, qual_own, qual_any, inc_own, inc_any;
   logic [1:0]        priv_level = '0;
   logic [255:0]      evt_own, evt_any;
   int                fail_count = 0, checks = 0;
   always #2.5 clk_sys = ~clk_sys;
   evt_src_model m (.hit(hit), .any(any), .q(q), .inc(inc), .e_own(evt_own), .e_any(evt_any),
      .q_own(qual_own), .q_any(qual_any), .i_own(inc_own), .i_any(inc_any));
   perf_event_counter_control dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_own(evt_own),
      .evt_any(evt_any), .qual_own(qual_own), .qual_any(qual_any), .inc_own(inc_own), .inc_any(inc_any),
      .priv_level(priv_level), .ovf_irq(ovf_irq));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e)
      begin
         $display("BAD %s exp %h got %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk($sformatf("reg%0h", a), e, reg_rdata);
   endtask
   // four cycles of the event, then the count is read back
   task automatic go(input logic [31:0] c, input logic a, input logic [7:0] qq, ii, input logic [1:0] p,
                     input logic [31:0] e);
      wr(ADDR_COUNT_LO, ZERO_WORD);
      any <= a;
      q <= qq;
      inc <= ii;
      priv_level <= p;
      wr(ADDR_CONTROL, c);
      hit <= 1'b1;
      repeat (4) @(posedge clk_sys);
      hit <= 1'b0;
      wr(ADDR_CONTROL, ZERO_WORD);
      rd(ADDR_COUNT_LO, e);
   endtask
   task automatic t_regs;
      rd(ADDR_CONTROL, CONTROL_RESET);
      wr(ADDR_CONTROL, 32'hffffffff);
      rd(ADDR_CONTROL, CONTROL_WMASK);
      rd(4'hf, ZERO_WORD);
      priv_level <= 2'h2;
      rd(ADDR_PRIV_LEVEL, 32'h2);
      wr(ADDR_CONTROL, ZERO_WORD);
      $display("t_regs done");
   endtask
   task automatic t_count;
      go(32'h00410005, 0, 8'h00, 8'h00, 2'h3, 4);
      go(32'h00410006, 0, 8'h00, 8'h00, 2'h3, 0);
      go(32'h00410005, 0, 8'h00, 8'h00, 2'h0, 0);
      go(32'h00420005, 0, 8'h00, 8'h00, 2'h0, 4);
      go(32'h00420005, 0, 8'h00, 8'h00, 2'h2, 0);
      go(32'h00010005, 0, 8'h00, 8'h00, 2'h3, 0);
      go(32'h00450005, 0, 8'h00, 8'h00, 2'h3, 1);
      go(32'h00410005, 1, 8'h00, 8'h00, 2'h3, 0);
      go(32'h00610005, 1, 8'h00, 8'h00, 2'h3, 4);
      go(32'h00410105, 0, 8'h02, 8'h00, 2'h3, 0);
      go(32'h00410105, 0, 8'h01, 8'h00, 2'h3, 4);
      go(32'h03410005, 0, 8'h00, 8'h03, 2'h3, 4);
      go(32'h03410005, 0, 8'h00, 8'h02, 2'h3, 0);
      go(32'h03c10005, 0, 8'h00, 8'h02, 2'h3, 4);
      go(32'h03c10005, 0, 8'h00, 8'h03, 2'h3, 0);
      $display("t_count done");
   endtask
   task automatic t_ovf;
      for (int i = 0; i < 2; i++)
      begin
         wr(ADDR_COUNT_HI, 32'h0000ffff);
         wr(ADDR_COUNT_LO, 32'hffffffff);
         priv_level <= 2'h3;
         wr(ADDR_CONTROL, i ? 32'h00510005 : 32'h00410005);
         hit <= 1'b1;
         @(posedge clk_sys);
         hit <= 1'b0;
         #1 chk("ovf_irq", 32'(i), {31'h0, ovf_irq});
         @(posedge clk_sys);
         #1 chk("ovf_irq", ZERO_WORD, {31'h0, ovf_irq});
         wr(ADDR_CONTROL, ZERO_WORD);
         rd(ADDR_COUNT_LO, ZERO_WORD);
         rd(ADDR_COUNT_HI, ZERO_WORD);
         rd(ADDR_STATUS, 32'h00000001);
         wr(ADDR_STATUS, 32'h00000001);
         rd(ADDR_STATUS, ZERO_WORD);
      end
      $display("t_ovf done");
   endtask
   // clock enable low freezes the counter even with the event present
   task automatic t_freeze;
      wr(ADDR_COUNT_LO, ZERO_WORD);
      priv_level <= 2'h3;
      wr(ADDR_CONTROL, 32'h00410005);
      clk_en <= 1'b0;
      hit <= 1'b1;
      repeat (4) @(posedge clk_sys);
      hit <= 1'b0;
      clk_en <= 1'b1;
      wr(ADDR_CONTROL, ZERO_WORD);
      rd(ADDR_COUNT_LO, ZERO_WORD);
      $display("t_freeze done");
   endtask
   initial
   begin
      #400000;
      fail_count++;
      wrap_up;
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs;
      t_count;
      t_ovf;
      t_freeze;
      wrap_up;
   end
endmodule
